/* File: common/mdio_mgmt_pkg.sv */
// Purpose : constants for the management serial master
// Assumes : byte address is word index times four
// Notes   : shared by the core and the bench
package mdio_mgmt_pkg;
    // ----------------------------------------------------------------
    // register indices
    // ----------------------------------------------------------------
    localparam logic [15:0] CMD_IDX       = 16'h0680;
    localparam logic [15:0] DATA_IDX      = 16'h0681;
    localparam logic [15:0] MASK_IDX      = 16'h0682;
    localparam logic [15:0] CTRL_IDX      = 16'h0683;
    localparam logic [15:0] POLL_IDX      = 16'h0684;
    localparam logic [1:0]  WORD_SHIFT    = 2'h2;
    // ----------------------------------------------------------------
    // fields, masks, resets
    // ----------------------------------------------------------------
    localparam int          CMD_GO_BIT    = 20;
    localparam int          OP_LSB        = 16;
    localparam int          PHY_LSB       = 8;
    localparam int          REG_LSB       = 0;
    localparam int          RDATA_LSB     = 16;
    localparam int          POLL_ADDR_LSB = 16;
    localparam int          CTL_SPEED_BIT = 0;
    localparam int          CTL_AUTO_BIT  = 1;
    localparam int          CTL_PEN_BIT   = 2;
    localparam int          CTL_BUSY_BIT  = 3;
    localparam logic [31:0] CMD_WMASK     = 32'h0013_031f;
    localparam logic [31:0] DATA_WMASK    = 32'h0000_ffff;
    localparam logic [31:0] MASK_WMASK    = 32'h0000_000f;
    localparam logic [31:0] CTRL_WMASK    = 32'h0000_0007;
    localparam logic [31:0] CMD_RESET     = 32'h0001_0000;
    localparam logic [31:0] MASK_RESET    = 32'h0000_000f;
    // ----------------------------------------------------------------
    // operation codes and frame layout
    // ----------------------------------------------------------------
    localparam logic [1:0]  OP_WRITE      = 2'h1;
    localparam logic [1:0]  OP_READ       = 2'h2;
    localparam logic [1:0]  FRAME_START   = 2'h1;
    localparam logic [1:0]  TA_WRITE      = 2'h2;
    localparam logic [1:0]  TA_READ       = 2'h3;
    localparam logic [2:0]  PHY_HIGH      = 3'h0;
    localparam logic [31:0] PREAMBLE      = 32'hffff_ffff;
    localparam logic [5:0]  TA_FIRST_BIT  = 6'h2e;
    localparam logic [5:0]  DATA_FIRST    = 6'h30;
    localparam logic [5:0]  LAST_BIT      = 6'h3f;
    localparam logic [4:0]  POLL_REG      = 5'h01;
    // ----------------------------------------------------------------
    // bus responses
    // ----------------------------------------------------------------
    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;
    // ----------------------------------------------------------------
    // mdc timing
    // ----------------------------------------------------------------
    localparam int          LINK_PERIOD_PS = 48000;
    localparam int          SLOW_PERIOD_PS = 400000;
    localparam int          FAST_PERIOD_PS = 55556;
    localparam int          SLOW_HALF_RAW  = (SLOW_PERIOD_PS + 2 * LINK_PERIOD_PS - 1) / (2 * LINK_PERIOD_PS);
    localparam int          FAST_HALF_RAW  = (FAST_PERIOD_PS + 2 * LINK_PERIOD_PS - 1) / (2 * LINK_PERIOD_PS);
    localparam logic [7:0]  SLOW_HALF      = 8'(SLOW_HALF_RAW < 1 ? 1 : SLOW_HALF_RAW);
    localparam logic [7:0]  FAST_HALF      = 8'(FAST_HALF_RAW < 1 ? 1 : FAST_HALF_RAW);

    typedef enum logic [1:0]
    {
        LINK_IDLE  = 2'b01,
        LINK_FRAME = 2'b10
    } link_state_t;
endpackage

/* File: core/mdio_management_master.sv */
// Purpose : management serial master with register set over axi4-lite
// Assumes : copper_mode set by port setup
// Notes   : frame on link_clock, toggle handshakes
module mdio_management_master
(
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        link_clock,
    input  wire logic [3:0]  copper_mode,
    input  wire logic [15:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [15:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             mdc,
    output logic             mdio_out,
    output logic             mdio_oe,
    input  wire logic        mdio_in
);
    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic [2:0] reg_sel(input logic [15:0] addr);
        logic [15:0] idx;
        idx = addr >> mdio_mgmt_pkg::WORD_SHIFT;
        if (addr[1:0] != 2'h0)
            reg_sel = 3'h7;
        else if (idx == mdio_mgmt_pkg::CMD_IDX)
            reg_sel = 3'h0;
        else if (idx == mdio_mgmt_pkg::DATA_IDX)
            reg_sel = 3'h1;
        else if (idx == mdio_mgmt_pkg::MASK_IDX)
            reg_sel = 3'h2;
        else if (idx == mdio_mgmt_pkg::CTRL_IDX)
            reg_sel = 3'h3;
        else if (idx == mdio_mgmt_pkg::POLL_IDX)
            reg_sel = 3'h4;
        else
            reg_sel = 3'h7;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                          input logic [3:0] strb, input logic [31:0] wmask);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
        merge = (old & ~m) | (data & m);
    endfunction

    // ----------------------------------------------------------------
    // register storage
    // ----------------------------------------------------------------
    logic [31:0] cmd_ff;
    logic [15:0] wdata_ff;
    logic [15:0] rdata_ff;
    logic [3:0]  mask_ff;
    logic [2:0]  ctrl_ff;
    logic [1:0]  poll_addr_ff;
    logic [15:0] poll_data_ff;
    logic        busy_ff;
    logic        wr_en;
    logic [2:0]  wr_sel;
    logic [2:0]  rd_sel;
    logic        done_evt;
    logic        go_clear;
    logic [31:0] rd_word;

    assign wr_en  = s_axi_awready;
    assign wr_sel = reg_sel(s_axi_awaddr);
    assign rd_sel = reg_sel(s_axi_araddr);

    // ----------------------------------------------------------------
    // axi4-lite write channel
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= mdio_mgmt_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
            if (wr_en)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wr_sel == 3'h7) ? mdio_mgmt_pkg::RESP_SLVERR : mdio_mgmt_pkg::RESP_OKAY;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite read channel
    // ----------------------------------------------------------------
    always_comb
    begin
        rd_word = 32'h0000_0000;
        case (rd_sel)
            3'h0:    rd_word = cmd_ff;
            3'h1:    rd_word = {rdata_ff, wdata_ff};
            3'h2:    rd_word = {28'h000_0000, mask_ff};
            3'h3:    rd_word = {28'h000_0000, busy_ff && ctrl_ff[mdio_mgmt_pkg::CTL_PEN_BIT], ctrl_ff};
            3'h4:    rd_word = {14'h0000, poll_addr_ff, poll_data_ff};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= mdio_mgmt_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= (rd_sel == 3'h7) ? mdio_mgmt_pkg::RESP_SLVERR : mdio_mgmt_pkg::RESP_OKAY;
            end
            else if (s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // software registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            cmd_ff <= mdio_mgmt_pkg::CMD_RESET;
        else if (wr_en && wr_sel == 3'h0)
            cmd_ff <= merge(cmd_ff, s_axi_wdata, s_axi_wstrb, mdio_mgmt_pkg::CMD_WMASK);
        else if (go_clear)
            cmd_ff[mdio_mgmt_pkg::CMD_GO_BIT] <= 1'b0;
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            wdata_ff <= 16'h0000;
            mask_ff  <= 4'hf;
            ctrl_ff  <= 3'h0;
        end
        else if (wr_en)
        begin
            if (wr_sel == 3'h1)
                wdata_ff <= 16'(merge({16'h0000, wdata_ff}, s_axi_wdata, s_axi_wstrb, mdio_mgmt_pkg::DATA_WMASK));
            if (wr_sel == 3'h2)
                mask_ff <= 4'(merge(mdio_mgmt_pkg::MASK_RESET & {28'h000_0000, mask_ff}, s_axi_wdata,
                                    s_axi_wstrb, mdio_mgmt_pkg::MASK_WMASK));
            if (wr_sel == 3'h3)
                ctrl_ff <= 3'(merge({29'h0000_0000, ctrl_ff}, s_axi_wdata, s_axi_wstrb, mdio_mgmt_pkg::CTRL_WMASK));
        end
    end

    // ----------------------------------------------------------------
    // launch of single commands and polls
    // ----------------------------------------------------------------

    logic        pend_ff;
    logic        req_tgl_ff;
    logic [1:0]  scan_ptr_ff;
    logic [1:0]  l_op_ff;
    logic [1:0]  l_phy_ff;
    logic [4:0]  l_reg_ff;
    logic [15:0] l_wdata_ff;
    logic        l_speed_ff;
    logic        go_bit;
    logic [1:0]  cmd_phy;
    logic        start_single;
    logic        reject_single;
    logic        start_poll;

    assign go_bit        = cmd_ff[mdio_mgmt_pkg::CMD_GO_BIT];
    assign cmd_phy       = cmd_ff[mdio_mgmt_pkg::PHY_LSB +: 2];
    assign start_single  = !pend_ff && go_bit && copper_mode[cmd_phy];
    assign reject_single = !pend_ff && go_bit && !copper_mode[cmd_phy];
    assign start_poll    = !pend_ff && !go_bit && ctrl_ff[mdio_mgmt_pkg::CTL_AUTO_BIT]
                           && mask_ff[scan_ptr_ff] && copper_mode[scan_ptr_ff];
    assign go_clear      = reject_single || (done_evt && busy_ff);

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            pend_ff    <= 1'b0;
            busy_ff    <= 1'b0;
            req_tgl_ff <= 1'b0;
            l_op_ff    <= mdio_mgmt_pkg::OP_READ;
            l_phy_ff   <= 2'h0;
            l_reg_ff   <= 5'h00;
            l_wdata_ff <= 16'h0000;
            l_speed_ff <= 1'b0;
        end
        else if (start_single || start_poll)
        begin
            pend_ff    <= 1'b1;
            busy_ff    <= start_single;
            req_tgl_ff <= !req_tgl_ff;
            l_op_ff    <= start_single ? cmd_ff[mdio_mgmt_pkg::OP_LSB +: 2] : mdio_mgmt_pkg::OP_READ;
            l_phy_ff   <= start_single ? cmd_phy : scan_ptr_ff;
            l_reg_ff   <= start_single ? cmd_ff[mdio_mgmt_pkg::REG_LSB +: 5] : mdio_mgmt_pkg::POLL_REG;
            l_wdata_ff <= wdata_ff;
            l_speed_ff <= ctrl_ff[mdio_mgmt_pkg::CTL_SPEED_BIT];
        end
        else if (done_evt)
        begin
            pend_ff <= 1'b0;
            busy_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            scan_ptr_ff <= 2'h0;
        else if (!pend_ff && !go_bit && (start_poll || ctrl_ff[mdio_mgmt_pkg::CTL_AUTO_BIT]))
            scan_ptr_ff <= scan_ptr_ff + 2'h1;
    end

    // ----------------------------------------------------------------
    // results back from the link
    // ----------------------------------------------------------------
    logic        done_s1_ff;
    logic        done_s2_ff;
    logic        done_s3_ff;
    logic        done_tgl_ff;
    logic [15:0] link_rd_ff;

    assign done_evt = done_s2_ff ^ done_s3_ff;

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            done_s1_ff <= 1'b0;
            done_s2_ff <= 1'b0;
            done_s3_ff <= 1'b0;
        end
        else
        begin
            done_s1_ff <= done_tgl_ff;
            done_s2_ff <= done_s1_ff;
            done_s3_ff <= done_s2_ff;
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata_ff     <= 16'h0000;
            poll_addr_ff <= 2'h0;
            poll_data_ff <= 16'h0000;
        end
        else if (done_evt && l_op_ff == mdio_mgmt_pkg::OP_READ)
        begin
            if (busy_ff)
                rdata_ff <= link_rd_ff;
            else
            begin
                poll_addr_ff <= l_phy_ff;
                poll_data_ff <= link_rd_ff;
            end
        end
    end

    // ----------------------------------------------------------------
    // link domain: request crossing and pin sampling
    // ----------------------------------------------------------------
    logic        req_s1_ff;
    logic        req_s2_ff;
    logic        req_s3_ff;
    logic        mdio_s1_ff;
    logic        mdio_s2_ff;
    logic        link_start;

    assign link_start = req_s2_ff ^ req_s3_ff;

    always_ff @(posedge link_clock or negedge resetn)
    begin
        if (!resetn)
        begin
            req_s1_ff  <= 1'b0;
            req_s2_ff  <= 1'b0;
            req_s3_ff  <= 1'b0;
            mdio_s1_ff <= 1'b1;
            mdio_s2_ff <= 1'b1;
        end
        else
        begin
            req_s1_ff  <= req_tgl_ff;
            req_s2_ff  <= req_s1_ff;
            req_s3_ff  <= req_s2_ff;
            mdio_s1_ff <= mdio_in;
            mdio_s2_ff <= mdio_s1_ff;
        end
    end

    // ----------------------------------------------------------------
    // link domain: frame engine
    // ----------------------------------------------------------------
    mdio_mgmt_pkg::link_state_t state_ff;
    logic [63:0] frame_ff;
    logic [5:0]  bit_idx_ff;
    logic [7:0]  div_ff;
    logic        is_read_ff;
    logic        half_done;
    logic [7:0]  half_len;

    assign half_len  = l_speed_ff ? mdio_mgmt_pkg::FAST_HALF : mdio_mgmt_pkg::SLOW_HALF;
    assign half_done = (div_ff + 8'h01 >= half_len);

    always_ff @(posedge link_clock or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff    <= mdio_mgmt_pkg::LINK_IDLE;
            frame_ff    <= 64'h0;
            bit_idx_ff  <= 6'h00;
            div_ff      <= 8'h00;
            is_read_ff  <= 1'b0;
            mdc         <= 1'b0;
            mdio_out    <= 1'b1;
            mdio_oe     <= 1'b0;
            done_tgl_ff <= 1'b0;
            link_rd_ff  <= 16'h0000;
        end
        else
        begin
            case (state_ff)
                mdio_mgmt_pkg::LINK_IDLE:
                begin
                    mdc    <= 1'b0;
                    div_ff <= 8'h00;
                    if (link_start)
                    begin
                        frame_ff   <= {mdio_mgmt_pkg::PREAMBLE, mdio_mgmt_pkg::FRAME_START, l_op_ff,
                                       mdio_mgmt_pkg::PHY_HIGH, l_phy_ff, l_reg_ff,
                                       (l_op_ff == mdio_mgmt_pkg::OP_READ) ? mdio_mgmt_pkg::TA_READ
                                                                          : mdio_mgmt_pkg::TA_WRITE,
                                       l_wdata_ff};
                        is_read_ff <= (l_op_ff == mdio_mgmt_pkg::OP_READ);
                        bit_idx_ff <= 6'h00;
                        mdio_out   <= 1'b1;
                        mdio_oe    <= 1'b1;
                        state_ff   <= mdio_mgmt_pkg::LINK_FRAME;
                    end
                end
                mdio_mgmt_pkg::LINK_FRAME:
                begin
                    if (!half_done)
                        div_ff <= div_ff + 8'h01;
                    else
                    begin
                        div_ff <= 8'h00;
                        mdc    <= !mdc;
                        if (!mdc)
                        begin
                            if (is_read_ff && bit_idx_ff >= mdio_mgmt_pkg::DATA_FIRST)
                                link_rd_ff <= {link_rd_ff[14:0], mdio_s2_ff};
                        end
                        else if (bit_idx_ff == mdio_mgmt_pkg::LAST_BIT)
                        begin
                            mdio_oe     <= 1'b0;
                            mdio_out    <= 1'b1;
                            done_tgl_ff <= !done_tgl_ff;
                            state_ff    <= mdio_mgmt_pkg::LINK_IDLE;
                        end
                        else
                        begin
                            bit_idx_ff <= bit_idx_ff + 6'h01;
                            frame_ff   <= {frame_ff[62:0], 1'b0};
                            mdio_out   <= frame_ff[62];
                            mdio_oe    <= !(is_read_ff && bit_idx_ff + 6'h01 >= mdio_mgmt_pkg::TA_FIRST_BIT);
                        end
                    end
                end
                default:
                begin
                    state_ff <= mdio_mgmt_pkg::LINK_IDLE;
                    mdio_oe  <= 1'b0;
                end
            endcase
        end
    end
endmodule

/* File: tb/mdio_management_master_assertions.sv */
// Purpose : port checks
// Assumes : serial side runs on link_clock
// Notes   : bound to the master
module mdio_management_master_assertions
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic link_clock,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic mdc,
    input wire logic mdio_out,
    input wire logic mdio_oe
);
    logic [6:0] rises_ff;
    always_ff @(posedge link_clock or negedge resetn)
    begin
        if (!resetn)
            rises_ff <= 7'h00;
        else if ($rose(mdio_oe))
            rises_ff <= 7'h00;
        else if ($rose(mdc))
            rises_ff <= rises_ff + 7'h01;
    end
    property p_wr_resp;
        @(posedge clock) disable iff (!resetn) s_axi_awvalid && s_axi_awready && s_axi_wready |=> s_axi_bvalid;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("bvalid missing");
    property p_aw_w_pair;
        @(posedge clock) disable iff (!resetn) $rose(s_axi_awready) |-> s_axi_wready;
    endproperty
    a_aw_w_pair: assert property (p_aw_w_pair) else $error("aw and w split");
    property p_rd_resp;
        @(posedge clock) disable iff (!resetn) s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_resp: assert property (p_rd_resp) else $error("rvalid missing");
    property p_ar_pulse;
        @(posedge clock) disable iff (!resetn) s_axi_arready |=> !s_axi_arready;
    endproperty
    a_ar_pulse: assert property (p_ar_pulse) else $error("arready held");
    property p_mdc_half;
        @(posedge link_clock) disable iff (!resetn) $rose(mdc) |=> !mdc or (mdc [*4] ##1 !mdc);
    endproperty
    a_mdc_half: assert property (p_mdc_half) else $error("mdc high length");
    property p_oe_edge;
        @(posedge link_clock) disable iff (!resetn) $changed(mdio_oe) |-> !mdc;
    endproperty
    a_oe_edge: assert property (p_oe_edge) else $error("oe moved, mdc high");
    property p_data_edge;
        @(posedge link_clock) disable iff (!resetn) $changed(mdio_out) && mdio_oe |-> !mdc;
    endproperty
    a_data_edge: assert property (p_data_edge) else $error("data moved, mdc high");
    property p_frame_len;
        @(posedge link_clock) disable iff (!resetn) $fell(mdio_oe) |-> rises_ff == 7'h40 || rises_ff == 7'h2e;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame length");
endmodule
bind mdio_management_master mdio_management_master_assertions mdio_management_master_assertions_i
(
    .clock(clock), .resetn(resetn), .link_clock(link_clock), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
    .mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe)
);

/* File: tb/phy_model.sv */
// Purpose : phy on the management pair
// Assumes : data line pulled up
// Notes   : read data driven DLY after mdc rise
module phy_model
#(
    parameter int DLY = 5
)
(
    input  wire logic  mdc,
    input  wire logic  mdio,
    output logic       phy_out,
    output logic       phy_oe,
    output logic [1:0] op_seen,
    output logic [4:0] phy_seen,
    output logic [4:0] reg_seen,
    output logic [15:0] data_seen,
    output logic [7:0] n_frames
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [32];
    logic [15:0] sr;
    int          ones = 0;
    int          n = -1;
    initial
    begin
        phy_out = 1'b1;
        phy_oe = 1'b0;
        n_frames = 8'h00;
        for (int i = 0; i < 32; i++)
            mem[i] = 16'hc000 | 16'(i);
    end
    always @(posedge mdc)
    begin
        sr = {sr[14:0], mdio};
        n = (n >= 0) ? n + 1 : ((ones >= 32 && !mdio) ? 0 : -1);
        ones = mdio ? ones + 1 : 0;
        if (n == 3) op_seen = sr[1:0];
        if (n == 8) phy_seen = sr[4:0];
        if (n == 13) reg_seen = sr[4:0];
        if (op_seen == 2'h2 && n >= 14 && n <= 30)
        begin
            phy_oe <= #DLY 1'b1;
            phy_out <= #DLY (n == 14) ? 1'b0 : mem[reg_seen][30 - n];
        end
        if (n == 31)
        begin
            phy_oe <= #DLY 1'b0;
            data_seen = sr;
            if (op_seen == 2'h1)
                mem[reg_seen] = sr;
            n_frames = n_frames + 8'h01;
            n = -1;
            ones = 0;
        end
    end
endmodule

/* File: tb/mdio_management_master_tb.sv */
// Purpose : directed register and frame checks
// Assumes : one phy model answers all addresses
// Notes   : reads and polls at slow mdc
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module mdio_management_master_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] A_CMD = mdio_mgmt_pkg::CMD_IDX << 2;
    localparam logic [15:0] A_DAT = mdio_mgmt_pkg::DATA_IDX << 2;
    localparam logic [15:0] A_MSK = mdio_mgmt_pkg::MASK_IDX << 2;
    localparam logic [15:0] A_CTL = mdio_mgmt_pkg::CTRL_IDX << 2;
    localparam logic [15:0] A_POL = mdio_mgmt_pkg::POLL_IDX << 2;
    logic        clock = 1'b0, resetn = 1'b0, link_clock = 1'b0;
    logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, mdc, mdio_out, mdio_oe, phy_out, phy_oe;
    logic [1:0]  bresp, rresp, rs, op_seen;
    logic [4:0]  phy_seen, reg_seen;
    logic [15:0] data_seen;
    logic [7:0]  n_frames, nf;
    logic [15:0] ra [4] = '{A_CMD, A_DAT, A_MSK, A_CTL};
    logic [31:0] rv [4] = '{32'h0001_0000, 32'h0, 32'h0000_000f, 32'h0};
    logic [31:0] wp [4] = '{32'hffec_fce0, 32'hffff_beef, 32'hffff_fff0, 32'hffff_fff8};
    logic [31:0] we [4] = '{32'h0, 32'h0000_beef, 32'h0, 32'h0};
    int          n_errors = 0, checks = 0;
    wire         mdio_in = mdio_oe ? mdio_out : (phy_oe ? phy_out : 1'b1);
    always #5 clock = ~clock;
    always #24 link_clock = ~link_clock;
    mdio_management_master mdio_management_master_i
    (
        .clock(clock), .resetn(resetn), .link_clock(link_clock), .copper_mode(4'hb),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .mdc(mdc), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdio_in(mdio_in)
    );
    phy_model phy_model_i
    (
        .mdc(mdc), .mdio(mdio_in), .phy_out(phy_out), .phy_oe(phy_oe), .op_seen(op_seen),
        .phy_seen(phy_seen), .reg_seen(reg_seen), .data_seen(data_seen), .n_frames(n_frames)
    );
    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw_ok = 1'b0;
        logic w_ok = 1'b0;
        @(posedge clock);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        do
        begin
            @(posedge clock);
            aw_ok |= awready;
            w_ok |= wready;
            {awvalid, wvalid} <= {!aw_ok, !w_ok};
        end
        while (!(aw_ok && w_ok));
        while (!bvalid)
            @(posedge clock);
        bready <= 1'b0;
        `CHK("bresp", er, bresp)
    endtask
    task automatic rdr(input logic [15:0] a);
        logic ok = 1'b0;
        @(posedge clock);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do
        begin
            @(posedge clock);
            ok |= arready;
            arvalid <= !ok;
        end
        while (!rvalid);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    task automatic cmd(input logic [31:0] ctl, input logic [31:0] c, input logic busy);
        wr(A_CTL, ctl, 2'h0);
        wr(A_CMD, c, 2'h0);
        rdr(A_CTL);
        `CHK("busy", busy, rd[3])
        rdr(A_CMD);
        for (int i = 0; i < 5000 && rd[20] !== 1'b0; i++)
            rdr(A_CMD);
        `CHK("go", 1'b0, rd[20])
    endtask
    task automatic wrap_up();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        repeat (100000) @(posedge clock);
        n_errors++;
        wrap_up();
    end
    initial
    begin
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        foreach (ra[i])
        begin
            rdr(ra[i]);
            `CHK("reset", rv[i], rd)
            wr(ra[i], wp[i], 2'h0);
            rdr(ra[i]);
            `CHK("masked", we[i], rd)
        end
        rdr(16'h1a14);
        `CHK("unmapped", mdio_mgmt_pkg::RESP_SLVERR, rs)
        wr(16'h1a14, 32'h1, mdio_mgmt_pkg::RESP_SLVERR);
        cmd(32'h5, 32'h0011_010a, 1'b1);
        `CHK("op", 2'h1, op_seen)
        `CHK("phy", 5'h01, phy_seen)
        `CHK("reg", 5'h0a, reg_seen)
        `CHK("payload", 16'hbeef, data_seen)
        cmd(32'h0, 32'h0012_030a, 1'b0);
        `CHK("op", 2'h2, op_seen)
        `CHK("phy", 5'h03, phy_seen)
        rdr(A_DAT);
        `CHK("read data", 32'hbeef_beef, rd)
        cmd(32'h0, 32'h0012_001f, 1'b0);
        rdr(A_DAT);
        `CHK("read data", 32'hc01f_beef, rd)
        nf = n_frames;
        cmd(32'h5, 32'h0011_020a, 1'b0);
        repeat (1000) @(posedge clock);
        `CHK("fiber", nf, n_frames)
        wr(A_MSK, 32'h2, 2'h0);
        wr(A_CTL, 32'h2, 2'h0);
        nf = n_frames;
        for (int i = 0; i < 30000 && n_frames < nf + 8'h02; i++)
            @(posedge clock);
        `CHK("poll phy", 5'h01, phy_seen)
        `CHK("poll reg", 5'h01, reg_seen)
        wr(A_CTL, 32'h0, 2'h0);
        rdr(A_POL);
        `CHK("poll result", 32'h0001_c001, rd)
        repeat (7000) @(posedge clock);
        nf = n_frames;
        repeat (7000) @(posedge clock);
        `CHK("poll stopped", nf, n_frames)
        wrap_up();
    end
endmodule
